/* File: logic/nv_access_pkg.sv */
// Contract
// - space select chooses eeprom or flash; reset eeprom
// - eeprom holds 256 bytes, low address only
// - flash uses 14-bit data, 15-bit address pairs
// - start bits set-only, hardware clears on completion
// - write start refused unless write gate set
// - write gate reset only at power-up, not by presetn
// - clearing write gate never cancels running write
// - reset during write sets abort flag
// - completion clears start, sets sticky done flag
// - write starts only after 55h, AAh, start
// - unlock key register reads as zero
// - eeprom read data ready next cycle, held
// - eeprom byte write erases then programs automatically
// - write and erase timed by internal timer
// - power-up timer blocks eeprom writes
// - flash writes gated per block, reads always
// - code protection locks programming port, not cpu
// - data protect bit zero locks port only
// - flash read uses second cycle, data after
package nv_access_pkg;

    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  OFF_ADDR_LOW      = 8'h00;
    localparam logic [7:0]  OFF_ADDR_HIGH     = 8'h04;
    localparam logic [7:0]  OFF_DATA_LOW      = 8'h08;
    localparam logic [7:0]  OFF_DATA_HIGH     = 8'h0C;
    localparam logic [7:0]  OFF_CONTROL       = 8'h10;
    localparam logic [7:0]  OFF_UNLOCK        = 8'h14;
    localparam logic [7:0]  OFF_FLAG2         = 8'h18;

    localparam int          CTL_READ_START    = 0;
    localparam int          CTL_WRITE_START   = 1;
    localparam int          CTL_WRITE_ENABLE  = 2;
    localparam int          CTL_WRITE_ABORT   = 3;
    localparam int          CTL_CONFIG_SEL    = 6;
    localparam int          CTL_PROGRAM_SEL   = 7;
    localparam int          FLAG2_WRITE_DONE  = 4;

    localparam logic [7:0]  KEY_FIRST         = 8'h55;
    localparam logic [7:0]  KEY_SECOND        = 8'hAA;
    localparam logic [7:0]  ERASED_BYTE       = 8'hFF;

    localparam int          EE_DEPTH          = 256;
    localparam int          FL_ADDR_W         = 15;
    localparam int          FL_DATA_W         = 14;
    localparam int          ADDR_HIGH_W       = FL_ADDR_W - 8;
    localparam int          DATA_HIGH_W       = FL_DATA_W - 8;

    localparam logic [1:0]  WP_NONE           = 2'b11;
    localparam logic [1:0]  WP_QUARTER        = 2'b10;
    localparam logic [1:0]  WP_HALF           = 2'b01;
    localparam logic [14:0] FL_QUARTER_END    = 15'h2000;
    localparam logic [14:0] FL_HALF_END       = 15'h4000;

    localparam int          CLK_MHZ           = 100;
    localparam int          PWRT_TIME_MS      = 64;
    localparam int          PWRT_CYCLES       = PWRT_TIME_MS * 1000 * CLK_MHZ;
    localparam int          EE_ERASE_TIME_US  = 2000;
    localparam int          EE_PROG_TIME_US   = 2000;
    localparam int          FL_PROG_TIME_US   = 2000;
    localparam int          EE_ERASE_CYCLES   = EE_ERASE_TIME_US * CLK_MHZ;
    localparam int          EE_PROG_CYCLES    = EE_PROG_TIME_US * CLK_MHZ;
    localparam int          FL_PROG_CYCLES    = FL_PROG_TIME_US * CLK_MHZ;
    localparam int          TMR_W             = 24;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } key_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FL_SLOT,
        ST_EE_ERASE,
        ST_EE_PROG,
        ST_FL_PROG
    } nv_state_e;

    typedef struct packed {
        logic program_space;
        logic config_space;
    } space_s;

endpackage : nv_access_pkg

/* File: logic/eeprom_flash_self_access.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_flash_self_access
    import nv_access_pkg::*;
#(
    parameter int EE_ERASE_CYC = EE_ERASE_CYCLES,
    parameter int EE_PROG_CYC  = EE_PROG_CYCLES,
    parameter int FL_PROG_CYC  = FL_PROG_CYCLES,
    parameter int PWRT_CYC     = PWRT_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 por_n,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [1:0]           self_write_protect_sel,
    input  wire logic                 data_protect_bit,
    input  wire logic                 program_protect_bit,
    output logic                      core_hold,
    input  wire logic                 prog_port_req,
    input  wire logic                 prog_port_space,
    input  wire logic [FL_ADDR_W-1:0] prog_port_addr,
    output logic [FL_DATA_W-1:0]      prog_port_rdata,
    output logic                      prog_port_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // storage and state

    logic [7:0]             ee_mem [EE_DEPTH];
    logic [FL_DATA_W-1:0]   fl_mem [2**FL_ADDR_W];

    logic [7:0]             addr_low;
    logic [ADDR_HIGH_W-1:0] addr_high;
    logic [7:0]             data_low;
    logic [DATA_HIGH_W-1:0] data_high;
    space_s                 space;
    logic                   read_start;
    logic                   write_start;
    logic                   write_enable_gate;
    logic                   write_abort_flag;
    logic                   write_done_flag;
    logic                   write_in_flight;
    key_e                   key;
    nv_state_e              state;
    logic [TMR_W-1:0]       timer;
    logic [TMR_W-1:0]       pwrt_cnt;
    logic [FL_ADDR_W-1:0]   tgt_addr;
    logic [FL_DATA_W-1:0]   tgt_data;
    logic [2:0]             req_sync;
    logic                   req_level;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire                    setup      = psel & ~penable;
    wire                    access     = psel & penable & pready;
    wire                    hit_alow   = (paddr == OFF_ADDR_LOW);
    wire                    hit_ahigh  = (paddr == OFF_ADDR_HIGH);
    wire                    hit_dlow   = (paddr == OFF_DATA_LOW);
    wire                    hit_dhigh  = (paddr == OFF_DATA_HIGH);
    wire                    hit_ctrl   = (paddr == OFF_CONTROL);
    wire                    hit_unlock = (paddr == OFF_UNLOCK);
    wire                    hit_flag2  = (paddr == OFF_FLAG2);
    wire                    mapped     = hit_alow | hit_ahigh | hit_dlow | hit_dhigh
                                         | hit_ctrl | hit_unlock | hit_flag2;
    wire                    wr_acc     = access & pwrite & ~pslverr;
    wire                    wr_ctrl    = wr_acc & hit_ctrl;

    wire [7:0]              ctrl_view  = {space.program_space, space.config_space, 2'b00,
                                          write_abort_flag, write_enable_gate,
                                          write_start, read_start};
    // key register always reads zero
    wire [31:0]             read_mux   =
        hit_alow  ? {24'h000000, addr_low} :
        hit_ahigh ? {{(32-ADDR_HIGH_W){1'b0}}, addr_high} :
        hit_dlow  ? {24'h000000, data_low} :
        hit_dhigh ? {{(32-DATA_HIGH_W){1'b0}}, data_high} :
        hit_ctrl  ? {24'h000000, ctrl_view} :
        hit_flag2 ? {27'h0000000, write_done_flag, 4'h0} :
        32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // start qualification

    // 15-bit word address from the register pair
    wire [FL_ADDR_W-1:0]    fl_addr    = {addr_high, addr_low};
    wire [FL_DATA_W-1:0]    fl_data    = {data_high, data_low};
    wire                    pwrt_running = (pwrt_cnt != {TMR_W{1'b0}});
    // block map for self writes
    wire                    fl_blocked =
        (self_write_protect_sel == WP_NONE)    ? 1'b0 :
        (self_write_protect_sel == WP_QUARTER) ? (fl_addr < FL_QUARTER_END) :
        (self_write_protect_sel == WP_HALF)    ? (fl_addr < FL_HALF_END) :
        1'b1;
    // eeprom writes held off while power-up timer runs
    wire                    space_ok   = ~space.config_space
                                         & (space.program_space ? ~fl_blocked : ~pwrt_running);
    wire                    idle       = (state == ST_IDLE) & ~read_start & ~write_start;
    // exact key order, gate already set, else nothing happens
    wire                    start_write = wr_ctrl & pwdata[CTL_WRITE_START] & (key == KEY_ARMED)
                                          & write_enable_gate & idle & space_ok;
    wire                    start_read = wr_ctrl & pwdata[CTL_READ_START] & idle;
    wire                    tmr_zero   = (timer == {TMR_W{1'b0}});
    wire                    done_evt   = tmr_zero & ((state == ST_EE_PROG) | (state == ST_FL_PROG));
    wire                    ee_read_now = read_start & (state == ST_IDLE) & ~space.program_space;
    wire                    fl_read_now = (state == ST_FL_SLOT);
    wire                    flag2_clr  = wr_acc & hit_flag2 & ~pwdata[FLAG2_WRITE_DONE];
    wire                    abort_clr  = wr_ctrl & ~pwdata[CTL_WRITE_ABORT];
    wire                    reset_cut  = write_in_flight & (state == ST_IDLE) & ~write_start;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, no wait states, error on unmapped address

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup & ~pwrite) begin
                prdata <= read_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock key sequencer; any other write to a mapped address disarms

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key <= KEY_IDLE;
        end else if (wr_acc) begin
            if (hit_unlock && pwdata[7:0] == KEY_FIRST && key == KEY_IDLE) begin
                key <= KEY_GOT_FIRST;
            end else if (hit_unlock && pwdata[7:0] == KEY_SECOND && key == KEY_GOT_FIRST) begin
                key <= KEY_ARMED;
            end else begin
                key <= KEY_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address, data and space registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low  <= 8'h00;
            addr_high <= '0;
            space     <= '0;
        end else begin
            if (wr_acc && hit_alow) begin
                addr_low <= pwdata[7:0];
            end
            if (wr_acc && hit_ahigh) begin
                addr_high <= pwdata[ADDR_HIGH_W-1:0];
            end
            if (wr_ctrl) begin
                space.program_space <= pwdata[CTL_PROGRAM_SEL];
                space.config_space  <= pwdata[CTL_CONFIG_SEL];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_low  <= 8'h00;
            data_high <= '0;
        end else if (ee_read_now) begin
            // byte lands one cycle after the read start, cpu path ignores protect
            data_low <= space.config_space ? 8'h00 : ee_mem[addr_low];
        end else if (fl_read_now) begin
            // flash reads never gated by write protect
            data_low  <= space.config_space ? 8'h00 : fl_mem[fl_addr][7:0];
            data_high <= space.config_space ? '0 : fl_mem[fl_addr][FL_DATA_W-1:8];
        end else begin
            if (wr_acc && hit_dlow) begin
                data_low <= pwdata[7:0];
            end
            if (wr_acc && hit_dhigh) begin
                data_high <= pwdata[DATA_HIGH_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operation sequencer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_IDLE;
            timer       <= '0;
            read_start  <= 1'b0;
            write_start <= 1'b0;
            core_hold   <= 1'b0;
            tgt_addr    <= '0;
            tgt_data    <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_read) begin
                        read_start <= 1'b1;
                    end else if (start_write) begin
                        write_start <= 1'b1;
                        tgt_addr    <= space.program_space ? fl_addr : {7'h00, addr_low};
                        tgt_data    <= fl_data;
                        if (space.program_space) begin
                            state     <= ST_FL_PROG;
                            timer     <= TMR_W'(FL_PROG_CYC - 1);
                            core_hold <= 1'b1;
                        end else begin
                            state <= ST_EE_ERASE;
                            timer <= TMR_W'(EE_ERASE_CYC - 1);
                        end
                    end else if (ee_read_now) begin
                        read_start <= 1'b0;
                    end else if (read_start) begin
                        state     <= ST_FL_SLOT;
                        core_hold <= 1'b1;
                    end
                end
                ST_FL_SLOT: begin
                    read_start <= 1'b0;
                    core_hold  <= 1'b0;
                    state      <= ST_IDLE;
                end
                ST_EE_ERASE: begin
                    if (tmr_zero) begin
                        state <= ST_EE_PROG;
                        timer <= TMR_W'(EE_PROG_CYC - 1);
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                ST_EE_PROG, ST_FL_PROG: begin
                    // write gate no longer consulted once running
                    if (tmr_zero) begin
                        write_start <= 1'b0;
                        core_hold   <= 1'b0;
                        state       <= ST_IDLE;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // arrays are nonvolatile: no reset
    always_ff @(posedge pclk) begin
        if (state == ST_EE_ERASE && tmr_zero) begin
            ee_mem[tgt_addr[7:0]] <= ERASED_BYTE;
        end
        if (state == ST_EE_PROG && tmr_zero) begin
            ee_mem[tgt_addr[7:0]] <= tgt_data[7:0];
        end
        if (state == ST_FL_PROG && tmr_zero) begin
            fl_mem[tgt_addr] <= tgt_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags; set wins over software clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_done_flag <= 1'b0;
        end else begin
            write_done_flag <= done_evt | (write_done_flag & ~flag2_clr);
        end
    end

    // power-up domain: survives ordinary resets
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            write_enable_gate <= 1'b0;
            write_in_flight   <= 1'b0;
            write_abort_flag  <= 1'b0;
            pwrt_cnt          <= TMR_W'(PWRT_CYC - 1);
        end else begin
            if (wr_ctrl) begin
                write_enable_gate <= pwdata[CTL_WRITE_ENABLE];
            end
            if (pwrt_running) begin
                pwrt_cnt <= pwrt_cnt - 1'b1;
            end
            // idle sequencer with a write still marked means a reset cut it off
            write_in_flight  <= start_write | (write_in_flight & ~done_evt & ~reset_cut);
            write_abort_flag <= reset_cut | (write_abort_flag & ~abort_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external programming port, read only, locked by protect bits

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_sync        <= 3'b000;
            req_level       <= 1'b0;
            prog_port_valid <= 1'b0;
            prog_port_rdata <= '0;
        end else begin
            req_sync        <= {req_sync[1:0], prog_port_req};
            prog_port_valid <= 1'b0;
            if (req_sync[1] == req_sync[2] && req_sync[2] != req_level) begin
                req_level <= req_sync[2];
                if (req_sync[2]) begin
                    prog_port_valid <= 1'b1;
                    if (prog_port_space) begin
                        prog_port_rdata <= program_protect_bit ? fl_mem[prog_port_addr]
                                                               : '0;
                    end else begin
                        prog_port_rdata <= data_protect_bit
                            ? {6'h00, ee_mem[prog_port_addr[7:0]]} : '0;
                    end
                end
            end
        end
    end

endmodule : eeprom_flash_self_access
`default_nettype wire

/* File: bench/nv_access_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module nv_access_properties
    import nv_access_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 por_n,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [1:0]           self_write_protect_sel,
    input wire logic                 data_protect_bit,
    input wire logic                 program_protect_bit,
    input wire logic                 core_hold,
    input wire logic                 prog_port_req,
    input wire logic                 prog_port_space,
    input wire logic [FL_ADDR_W-1:0] prog_port_addr,
    input wire logic [FL_DATA_W-1:0] prog_port_rdata,
    input wire logic                 prog_port_valid
);
    logic [1:0] sel_q;
    logic       gate_q;
    wire        wr_ctl = psel && penable && pready && pwrite && (paddr == OFF_CONTROL);
    wire        rd_set = psel && !penable && !pwrite;

    // selects and gate as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sel_q <= 2'b00;
        else if (wr_ctl) sel_q <= pwdata[7:6];
    end
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) gate_q <= 1'b0;
        else if (wr_ctl) gate_q <= pwdata[CTL_WRITE_ENABLE];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_pulse; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a single pulse");
    property p_unlock_zero; rd_set && paddr == OFF_UNLOCK |=> prdata == 32'h0; endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock key read nonzero");
    property p_data_high_width; rd_set && paddr == OFF_DATA_HIGH |=> prdata[31:DATA_HIGH_W] == '0;
    endproperty
    a_data_high_width: assert property (p_data_high_width) else $error("data high too wide");
    property p_addr_high_width; rd_set && paddr == OFF_ADDR_HIGH |=> prdata[31:ADDR_HIGH_W] == '0;
    endproperty
    a_addr_high_width: assert property (p_addr_high_width) else $error("addr high too wide");
    property p_select_kept; rd_set && paddr == OFF_CONTROL |=> prdata[7:6] == sel_q; endproperty
    a_select_kept: assert property (p_select_kept) else $error("space select wrong");
    property p_gate_kept; rd_set && paddr == OFF_CONTROL |=> prdata[CTL_WRITE_ENABLE] == gate_q;
    endproperty
    a_gate_kept: assert property (p_gate_kept) else $error("write gate changed");
    property p_flash_slot;
        wr_ctl && sel_q == 2'b10 && pwdata[7:6] == 2'b10 && pwdata[CTL_READ_START]
            |=> ##1 core_hold ##1 !core_hold;
    endproperty
    a_flash_slot: assert property (p_flash_slot) else $error("flash read slot wrong");
    property p_port_ee_lock; prog_port_valid && !prog_port_space && !data_protect_bit
        |-> prog_port_rdata == '0; endproperty
    a_port_ee_lock: assert property (p_port_ee_lock) else $error("eeprom leaked to port");
    property p_port_fl_lock; prog_port_valid && prog_port_space && !program_protect_bit
        |-> prog_port_rdata == '0; endproperty
    a_port_fl_lock: assert property (p_port_fl_lock) else $error("flash leaked to port");

    c_flash_slot: cover property (wr_ctl && sel_q == 2'b10 && pwdata[CTL_READ_START]);
    c_port_read: cover property (prog_port_valid && prog_port_space);
    c_slave_err: cover property (pready && pslverr);
endmodule : nv_access_properties

bind eeprom_flash_self_access nv_access_properties nv_access_properties_i (.*);
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nv_access_pkg::*;
    logic                 pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
    logic                 data_protect_bit, program_protect_bit, core_hold;
    logic                 prog_port_req, prog_port_space, prog_port_valid;
    logic [ADDR_W-1:0]    paddr;
    logic [31:0]          pwdata, prdata, seed;
    logic [1:0]           self_write_protect_sel;
    logic [FL_ADDR_W-1:0] prog_port_addr;
    logic [FL_DATA_W-1:0] prog_port_rdata;
    logic [32:0]          exp_q[$];
    logic [FL_DATA_W-1:0] port_q[$];
    logic [7:0]           a, d, ffd;
    int                   n_errors, n_tests, cycles;

    eeprom_flash_self_access #(.EE_ERASE_CYC(5), .EE_PROG_CYC(5), .FL_PROG_CYC(5), .PWRT_CYC(40))
    eeprom_flash_self_access_i (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    // one transfer, then an idle cycle; expected {slverr, rdata} queued
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= ad;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        apb(1'b1, ad, {24'h0, wd}, 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0, {1'b0, e});
    endtask : rd

    task automatic nv_write(input logic [7:0] sel, ah, al, dh, dl, k1, k2, input logic g);
        wr(OFF_ADDR_LOW, al);
        wr(OFF_ADDR_HIGH, ah);
        wr(OFF_DATA_LOW, dl);
        wr(OFF_DATA_HIGH, dh);
        wr(OFF_CONTROL, sel | {5'h0, g, 2'b00});
        wr(OFF_UNLOCK, k1);
        wr(OFF_UNLOCK, k2);
        wr(OFF_CONTROL, sel | {5'h0, g, 2'b10});
    endtask : nv_write

    task automatic rst(input logic p);
        presetn <= 1'b0;
        if (p) por_n <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : rst
////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin : monitor
        logic [32:0] e;
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            check({31'h0, pslverr}, {31'h0, e[32]}, "slave error");
            if (!pwrite && !e[32]) check(prdata, e[31:0], "read data");
        end
        if (prog_port_valid === 1'b1) check({18'h0, prog_port_rdata}, {18'h0, port_q.pop_front()},
                                            "port data");
        cycles++;
        if (cycles > 4000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        {psel, penable, pwrite, prog_port_req, prog_port_space} = 5'h0;
        {paddr, pwdata, prog_port_addr, data_protect_bit, program_protect_bit} = '0;
        {presetn, por_n, n_errors, n_tests, cycles} = '0;
        self_write_protect_sel = WP_NONE;
        seed = 32'h3C9ACD79;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
        nv_write(8'h0, 8'h0, 8'h10, 8'h0, 8'h5A, KEY_FIRST, KEY_SECOND, 1'b1);
        repeat (16) @(posedge pclk);
        rd(OFF_FLAG2, 32'h0);
        rd(OFF_CONTROL, 32'h04);
        rd(OFF_UNLOCK, 32'h0);
        apb(1'b0, 8'h1C, 32'h0, 33'h1_0000_0000);
        $display("test powerup done");
        for (int i = 0; i < 3; i++) begin
            nv_write(8'h0, 8'h0, 8'h20, 8'h0, 8'hC3, i == 1 ? KEY_SECOND : KEY_FIRST,
                     i == 0 ? KEY_SECOND : KEY_FIRST, i != 0);
            repeat (14) @(posedge pclk);
            rd(OFF_FLAG2, 32'h0);
            rd(OFF_CONTROL, i != 0 ? 32'h04 : 32'h00);
        end
        $display("test refused done");
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            a = i != 0 ? seed[7:0] : 8'hFF;
            d = seed[15:8];
            if (i == 0) ffd = d;
            nv_write(8'h0, i != 0 ? 8'h7F : 8'h0, a, 8'h0, d, KEY_FIRST, KEY_SECOND, 1'b1);
            wr(OFF_CONTROL, i != 0 ? 8'h04 : 8'h00);
            rd(OFF_CONTROL, i != 0 ? 32'h06 : 32'h02);
            repeat (14) @(posedge pclk);
            rd(OFF_FLAG2, 32'h10);
            rd(OFF_CONTROL, i != 0 ? 32'h04 : 32'h00);
            wr(OFF_FLAG2, 8'h0);
            rd(OFF_FLAG2, 32'h0);
            wr(OFF_ADDR_LOW, a);
            wr(OFF_CONTROL, 8'h01);
            rd(OFF_DATA_LOW, {24'h0, d});
        end
        $display("test eeprom done");
        nv_write(8'h80, 8'h12, 8'h34, 8'h2A, 8'hBC, KEY_FIRST, KEY_SECOND, 1'b1);
        repeat (14) @(posedge pclk);
        rd(OFF_FLAG2, 32'h10);
        wr(OFF_FLAG2, 8'h0);
        self_write_protect_sel <= WP_QUARTER;
        nv_write(8'h80, 8'h01, 8'h00, 8'h00, 8'h00, KEY_FIRST, KEY_SECOND, 1'b1);
        repeat (14) @(posedge pclk);
        rd(OFF_FLAG2, 32'h0);
        wr(OFF_ADDR_LOW, 8'h34);
        wr(OFF_ADDR_HIGH, 8'h12);
        wr(OFF_CONTROL, 8'h81);
        repeat (2) @(posedge pclk);
        rd(OFF_DATA_LOW, 32'hBC);
        rd(OFF_DATA_HIGH, 32'h2A);
        rst(1'b0);
        rd(OFF_CONTROL, 32'h00);
        $display("test flash done");
        nv_write(8'h0, 8'h0, 8'h40, 8'h0, 8'h99, KEY_FIRST, KEY_SECOND, 1'b1);
        repeat (2) @(posedge pclk);
        rst(1'b0);
        rd(OFF_CONTROL, 32'h0C);
        $display("test abort done");
        for (int i = 0; i < 4; i++) begin
            prog_port_space <= i[1];
            prog_port_addr <= i[1] ? 15'h1234 : 15'h00FF;
            data_protect_bit <= i[0];
            program_protect_bit <= i[0];
            port_q.push_back(!i[0] ? 14'h0 : i[1] ? 14'h2ABC : {6'h0, ffd});
            repeat (2) @(posedge pclk);
            prog_port_req <= 1'b1;
            repeat (8) @(posedge pclk);
            prog_port_req <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        check(32'(exp_q.size() + port_q.size()), 32'h0, "leftovers");
        $display("test port done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
